// file: rtl/card_atr_defs.svh
// register map, reset values and answer-to-reset constants of the card block
// How it works
// - class mask bits: 5 V, 3 V, 1.8 V
// - indicated classes must be adjacent only
// - answer-to-reset is first string after reset
// - answer always carries T=15 global parameters
// - first historical byte is category 80
// - first compact object is service tag 31
// - second compact object is capabilities tag 73
`ifndef CARD_ATR_DEFS_SVH
`define CARD_ATR_DEFS_SVH

// register offsets
`define OFS_CTRL        8'h00
`define OFS_CLASS       8'h04
`define OFS_SVC         8'h08
`define OFS_CAP         8'h0C
`define OFS_STATUS      8'h10
`define OFS_MASK        8'h14
`define OFS_STATE       8'h18

// field positions
`define CTRL_EN_BIT     0
`define CTRL_CSTOP_LSB  6
`define STS_DONE_BIT    0
`define STS_BADCLS_BIT  1
`define STS_RSTSEEN_BIT 2

// reset values
`define RST_EN          1'h1
`define RST_CSTOP       2'h0
`define RST_CLASS       3'h6
`define RST_SVC         8'hA0
`define RST_CAP         24'h0000C0
`define RST_MASK        3'h0

// answer-to-reset characters
`define ATR_TS          8'h3B
`define ATR_T0          8'h87
`define ATR_TD1         8'h80
`define ATR_TD2         8'h1F
`define HIST_CAT        8'h80
`define TAG_SVC         8'h31
`define TAG_CAP         8'h73
`define ATR_LAST        4'hC
`define CLS_SPLIT       3'h5

// timing counts: etu and answer delay in card clock periods, last bit index of a character in etus
`define ETU_CLKS        16'h0174
`define ATR_DELAY_CLKS  16'h01F4
`define CHAR_LAST       4'hB

`endif

// file: rtl/card_atr_pkg.sv
// types shared by the card answer-to-reset block
package card_atr_pkg;

  // sequencer states, gray along reset-wait-send-done
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SEND  = 2'b11,
    ST_DONE  = 2'b10
  } card_state_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // pin synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } sync_state_t;

  // whole state of the card core
  typedef struct packed {
    card_state_t st;
    logic [15:0] cnt;
    logic [3:0]  bit_idx;
    logic [3:0]  byte_idx;
    logic [9:0]  shreg;
    logic [7:0]  tck;
    logic [2:0]  cls_sent;
    logic        en;
    logic [1:0]  cstop;
    logic [2:0]  cls;
    logic [7:0]  svc;
    logic [23:0] cap;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [31:0] rdata;
    logic        irq;
    logic        io_oe;
    logic        io_out;
  } core_state_t;

endpackage

// file: rtl/card_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module card_pin_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin side
  input  wire logic pin,
  // filtered level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  card_atr_pkg::sync_state_t q;
  card_atr_pkg::sync_state_t n;

  // shift chain; level follows once stages two and three agree
  always_comb begin
    n      = q;
    n.s1   = pin;
    n.s2   = q.s1;
    n.s3   = q.s2;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (q.s2 == q.s3) begin
      n.lvl  = q.s3;
      n.rise = q.s3 & ~q.lvl;
      n.fall = ~q.s3 & q.lvl;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT, rise: 1'b0, fall: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign level = q.lvl;
  assign rise  = q.rise;
  assign fall  = q.fall;

endmodule // card_pin_sync
`default_nettype wire

// file: rtl/card_atr_core.sv
// card side answer-to-reset sequencer with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "card_atr_defs.svh"
module card_atr_core #(
  parameter logic [15:0] ETU_CLKS   = `ETU_CLKS,
  parameter logic [15:0] DELAY_CLKS = `ATR_DELAY_CLKS
) (
  // system clock and reset
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  // register port
  input  wire card_atr_pkg::reg_req_t  REG_REQ,
  output logic [31:0]                  REG_RDATA,
  // interrupt
  output logic                         IRQ,
  // card contacts
  input  wire logic                    CARD_CLK,
  input  wire logic                    CARD_RST_N,
  input  wire logic                    CARD_IO_IN,
  output logic                         CARD_IO_OUT,
  output logic                         CARD_IO_OE
);

  card_atr_pkg::core_state_t q;
  card_atr_pkg::core_state_t n;

  logic       cclk_lvl;
  logic       cclk_rise;
  logic       crst_lvl;
  logic       crst_rise;
  logic       crst_fall;
  logic       io_lvl;
  logic [2:0] sts_set;
  logic       etu_end;
  logic       cls_bad;
  logic [2:0] cls_ok;
  logic [7:0] next_byte;
  logic [3:0] next_idx;
  logic       sts_rd;

  // card clock sampled by the system clock
  card_pin_sync #(
    .INIT (1'b0)
  ) u_sync_clk (
    .clk   (CLK),
    .rst   (SYS_RST),
    .pin   (CARD_CLK),
    .level (cclk_lvl),
    .rise  (cclk_rise),
    .fall  ()
  );

  // card reset contact, active low
  card_pin_sync #(
    .INIT (1'b0)
  ) u_sync_rst (
    .clk   (CLK),
    .rst   (SYS_RST),
    .pin   (CARD_RST_N),
    .level (crst_lvl),
    .rise  (crst_rise),
    .fall  (crst_fall)
  );

  // serial line, pulled high outside
  card_pin_sync #(
    .INIT (1'b1)
  ) u_sync_io (
    .clk   (CLK),
    .rst   (SYS_RST),
    .pin   (CARD_IO_IN),
    .level (io_lvl),
    .rise  (),
    .fall  ()
  );

  // character frame: start bit low, eight data bits lsb first, even parity
  function automatic logic [9:0] frame(input logic [7:0] b);
    frame = {^b, b, 1'b0};
  endfunction

  // answer-to-reset byte at a given position
  function automatic logic [7:0] atr_byte(
    input logic [3:0]                idx,
    input card_atr_pkg::core_state_t s,
    input logic [2:0]                cls
  );
    case (idx)
      4'h0:    atr_byte = `ATR_TS;
      4'h1:    atr_byte = `ATR_T0;
      4'h2:    atr_byte = `ATR_TD1;
      4'h3:    atr_byte = `ATR_TD2;                  // global T=15 group
      4'h4:    atr_byte = {s.cstop, 3'h0, cls};      // class mask, reserved zero
      4'h5:    atr_byte = `HIST_CAT;                 // category first
      4'h6:    atr_byte = `TAG_SVC;                  // service object first
      4'h7:    atr_byte = s.svc;
      4'h8:    atr_byte = `TAG_CAP;                  // capabilities second
      4'h9:    atr_byte = s.cap[23:16];
      4'hA:    atr_byte = s.cap[15:8];
      4'hB:    atr_byte = s.cap[7:0];
      4'hC:    atr_byte = s.tck;
      default: atr_byte = 8'hFF;
    endcase
  endfunction

  // class mask check: a split mask falls back to the 5 V class alone
  always_comb begin
    cls_bad = (q.cls == `CLS_SPLIT);
    cls_ok  = cls_bad ? 3'h1 : q.cls;
  end

  // next byte to load within the answer
  always_comb begin
    next_idx  = q.byte_idx + 4'h1;
    next_byte = atr_byte(next_idx, q, q.cls_sent);
  end

  // etu timing on card clock rising edges
  always_comb begin
    etu_end = cclk_rise && (q.cnt == ETU_CLKS - 16'h0001);
  end

  // status read strobe
  always_comb begin
    sts_rd = REG_REQ.rd && (REG_REQ.addr == `OFS_STATUS);
  end

  // next state of the whole core
  always_comb begin
    n       = q;
    n.rdata = 32'h0;
    sts_set = 3'h0;

    // sequencer
    case (q.st)
      card_atr_pkg::ST_RESET: begin
        n.cnt = 16'h0000;
        if (crst_rise) begin
          n.st = card_atr_pkg::ST_WAIT;
        end
      end
      card_atr_pkg::ST_WAIT: begin
        if (cclk_rise && q.en) begin
          n.cnt = q.cnt + 16'h0001;
          if (q.cnt == DELAY_CLKS - 16'h0001) begin
            // answer opens the exchange after every reset
            n.st       = card_atr_pkg::ST_SEND;
            n.cnt      = 16'h0000;
            n.byte_idx = 4'h0;
            n.bit_idx  = 4'h0;
            n.shreg    = frame(`ATR_TS);
            n.tck      = 8'h00;
            n.cls_sent = cls_ok;
            sts_set[`STS_BADCLS_BIT] = cls_bad;
          end
        end
      end
      card_atr_pkg::ST_SEND: begin
        if (cclk_rise) begin
          n.cnt = etu_end ? 16'h0000 : q.cnt + 16'h0001;
        end
        if (etu_end) begin
          if (q.bit_idx == `CHAR_LAST) begin
            if (q.byte_idx == `ATR_LAST) begin
              n.st = card_atr_pkg::ST_DONE;
              sts_set[`STS_DONE_BIT] = 1'b1;
            end else begin
              n.byte_idx = next_idx;
              n.bit_idx  = 4'h0;
              n.shreg    = frame(next_byte);
              if (next_idx != `ATR_LAST) begin
                n.tck = q.tck ^ next_byte;           // check over T0 onward
              end
            end
          end else begin
            // shift out, guard time fills with idle high
            n.shreg   = {1'b1, q.shreg[9:1]};
            n.bit_idx = q.bit_idx + 4'h1;
          end
        end
      end
      card_atr_pkg::ST_DONE: begin
        n.cnt = 16'h0000;
      end
      default: begin
        n.st = card_atr_pkg::ST_RESET;
      end
    endcase

    // reset contact low silences the card in any state
    if (!crst_lvl) begin
      n.st  = card_atr_pkg::ST_RESET;
      n.cnt = 16'h0000;
    end
    sts_set[`STS_RSTSEEN_BIT] = crst_fall;

    // register writes
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `OFS_CTRL: begin
          n.en    = REG_REQ.wdata[`CTRL_EN_BIT];
          n.cstop = REG_REQ.wdata[`CTRL_CSTOP_LSB +: 2];
        end
        `OFS_CLASS: n.cls  = REG_REQ.wdata[2:0];
        `OFS_SVC:   n.svc  = REG_REQ.wdata[7:0];
        `OFS_CAP:   n.cap  = REG_REQ.wdata[23:0];
        `OFS_MASK:  n.mask = REG_REQ.wdata[2:0];
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `OFS_CTRL:   n.rdata = {24'h0, q.cstop, 5'h0, q.en};
        `OFS_CLASS:  n.rdata = {29'h0, q.cls};
        `OFS_SVC:    n.rdata = {24'h0, q.svc};
        `OFS_CAP:    n.rdata = {8'h0, q.cap};
        `OFS_STATUS: n.rdata = {29'h0, q.status};
        `OFS_MASK:   n.rdata = {29'h0, q.mask};
        `OFS_STATE:  n.rdata = {16'h0, io_lvl, crst_lvl, cls_sent_rd(q), q.byte_idx,
                                q.bit_idx, q.st};
        default:     n.rdata = 32'h0;
      endcase
    end

    // sticky events: read clears, a new event in the same cycle wins
    n.status = (q.status & ~{3{sts_rd}}) | sts_set;
    n.irq    = |(n.status & n.mask);

    // open-drain line: drive low only for zero bits
    n.io_out = 1'b0;
    n.io_oe  = (n.st == card_atr_pkg::ST_SEND) && !n.shreg[0];
  end

  // class mask actually sent in the last answer
  function automatic logic [3:0] cls_sent_rd(input card_atr_pkg::core_state_t s);
    cls_sent_rd = {1'b0, s.cls_sent};
  endfunction

  // state register
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q          <= '0;
      q.st       <= card_atr_pkg::ST_RESET;
      q.shreg    <= 10'h3FF;
      q.en       <= `RST_EN;
      q.cstop    <= `RST_CSTOP;
      q.cls      <= `RST_CLASS;
      q.svc      <= `RST_SVC;
      q.cap      <= `RST_CAP;
      q.mask     <= `RST_MASK;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA   = q.rdata;
  assign IRQ         = q.irq;
  assign CARD_IO_OUT = q.io_out;
  assign CARD_IO_OE  = q.io_oe;

endmodule // card_atr_core
`default_nettype wire

// file: dv/card_atr_core_sva.sv
// port assertions for the card answer-to-reset block
`timescale 1ns/1ps
`default_nettype none
`include "card_atr_defs.svh"
module card_atr_core_sva #(
  parameter logic [15:0] ETU_CLKS   = 16'h0004,
  parameter logic [15:0] DELAY_CLKS = 16'h0004
) (
  // clock and reset
  input wire logic                   CLK,
  input wire logic                   SYS_RST,
  // register port
  input wire card_atr_pkg::reg_req_t REG_REQ,
  input wire logic [31:0]            REG_RDATA,
  input wire logic                   IRQ,
  // card contacts
  input wire logic                   CARD_CLK,
  input wire logic                   CARD_RST_N,
  input wire logic                   CARD_IO_IN,
  input wire logic                   CARD_IO_OUT,
  input wire logic                   CARD_IO_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // read data only in the cycle after a read
  property p_rd_idle; !$past(REG_REQ.rd) |-> REG_RDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_unmapped; REG_REQ.rd && REG_REQ.addr >= 8'h1C |=> REG_RDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // class mask holds three classes, reserved bits zero
  property p_class_bits; REG_REQ.rd && REG_REQ.addr == `OFS_CLASS |=> REG_RDATA[31:3] == 29'h0;
  endproperty
  a_class_bits: assert property (p_class_bits) else $error("class mask too wide");
  // open drain: never drives high
  property p_io_out; CARD_IO_OUT == 1'b0; endproperty
  a_io_out: assert property (p_io_out) else $error("io driven high");
  // line released when the card is held in reset and for eight cycles after reset is let go
  property p_release; $fell(CARD_RST_N) |-> ##[0:8] !CARD_IO_OE; endproperty
  a_release: assert property (p_release) else $error("io not released");
  property p_quiet; (!CARD_RST_N) [*8] |-> !CARD_IO_OE; endproperty
  a_quiet: assert property (p_quiet) else $error("io driven in reset");
  property p_hold_delay; $rose(CARD_RST_N) |-> !CARD_IO_OE [*8]; endproperty
  a_hold_delay: assert property (p_hold_delay) else $error("answer too early");
  // after a change the line drive holds for eight more cycles
  property p_bit_hold;
    disable iff (SYS_RST || !CARD_RST_N) $changed(CARD_IO_OE) |=> $stable(CARD_IO_OE) [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
endmodule // card_atr_core_sva
bind card_atr_core card_atr_core_sva #(.ETU_CLKS(ETU_CLKS), .DELAY_CLKS(DELAY_CLKS)) u_sva (
  .CLK(CLK), .SYS_RST(SYS_RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
  .CARD_CLK(CARD_CLK), .CARD_RST_N(CARD_RST_N), .CARD_IO_IN(CARD_IO_IN),
  .CARD_IO_OUT(CARD_IO_OUT), .CARD_IO_OE(CARD_IO_OE));
`default_nettype wire

// file: dv/card_terminal_model.sv
// terminal model: card clock, card reset and character receiver
`timescale 1ns/1ps
`default_nettype none
module card_terminal_model #(
  parameter int ETU = 4
) (
  // activation request and wired line
  input  wire logic      act,
  input  wire logic      io,
  // contacts driven by the terminal
  output var logic       card_clk,
  output var logic       card_rst_n,
  // received characters
  output var logic       rx_stb,
  output var logic [7:0] rx_byte,
  output var logic       rx_perr
);
  int         n;
  int         r;
  int         k;
  logic       busy;
  logic       armed;
  logic [8:0] sh;
  // card clock only while active, phase unrelated to the system clock
  initial begin
    {card_clk, card_rst_n, rx_stb, busy, armed} = 5'h00;
    r = 0;
    n = 0;
    #7;
    forever begin
      #80;
      if (act || card_clk) card_clk = ~card_clk;
    end
  end
  // only clock and reset during activation, reset dropped at once
  always @(posedge card_clk or negedge act) begin
    if (!act) begin
      r = 0;
      card_rst_n = 1'b0;
    end else if (r < 8) r = r + 1;
    else card_rst_n = 1'b1;
  end
  // every character taken in, whatever it carries
  always @(negedge card_clk) begin
    rx_stb = 1'b0;
    if (!card_rst_n) begin
      busy = 1'b0;
      armed = 1'b0;
    end else if (!busy) begin
      if (io) armed = 1'b1;
      else if (armed) begin
        busy = 1'b1;
        armed = 1'b0;
        n = 0;
      end
    end else begin
      n = n + 1;
      k = (n + 1 - ETU / 2) / ETU;
      if (k > 0 && k * ETU == n + 1 - ETU / 2) begin
        sh = {io, sh[8:1]};
        if (k == 9) begin
          rx_byte = sh[7:0];
          rx_perr = ^sh;
          rx_stb = 1'b1;
          busy = 1'b0;
        end
      end
    end
  end
endmodule // card_terminal_model
`default_nettype wire

// file: dv/tb_card_atr_core.sv
// self-checking bench for the card answer-to-reset block
`timescale 1ns/1ps
`default_nettype none
`include "card_atr_defs.svh"
module tb_card_atr_core;
  logic                   clk, sys_rst, act, irq, io_oe, io_out, cclk, crst_n, stb, perr;
  card_atr_pkg::reg_req_t req;
  logic [31:0]            rdat;
  logic [7:0]             rxb, sv;
  logic [7:0]             e [13];
  logic [7:0]             got [$];
  logic [2:0]             m;
  logic [1:0]             cs;
  logic [23:0]            cp;
  int                     err_count, total_checks, seed, i, it;
  wire logic              io;
  // pull-up line, low while the card pulls it
  assign io = (io_oe && !io_out) ? 1'b0 : 1'b1;
  card_atr_core #(.ETU_CLKS(16'h0004), .DELAY_CLKS(16'h0004)) u_dut (.CLK(clk),
    .SYS_RST(sys_rst), .REG_REQ(req), .REG_RDATA(rdat), .IRQ(irq), .CARD_CLK(cclk),
    .CARD_RST_N(crst_n), .CARD_IO_IN(io), .CARD_IO_OUT(io_out), .CARD_IO_OE(io_oe));
  card_terminal_model #(.ETU(4)) u_term (.act(act), .io(io), .card_clk(cclk),
    .card_rst_n(crst_n), .rx_stb(stb), .rx_byte(rxb), .rx_perr(perr));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // collect characters, each with even parity
  always @(posedge stb) begin
    got.push_back(rxb);
    chk(perr, 0);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // register accesses, read compared in the cycle after the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 chk(rdat, x);
  endtask
  // terminal's choice of class from an indicated mask, all three classes offered
  function automatic logic [2:0] term_class(input logic [2:0] ind);
    logic [2:0] msk;
    msk = (ind == 3'h0) ? 3'h1 : ind;                // no indication: 5 V only
    if (msk[2]) term_class = 3'h4;                   // lowest class tried first
    else if (msk[1]) term_class = 3'h2;              // then the next higher class, 3 V
    else if (msk[0]) term_class = 3'h1;              // then 5 V, indicated or taken by default
    else term_class = 3'h0;                          // nothing usable: reject
  endfunction
  task automatic wait_rx(input int n);
    for (int k = 0; k < 20000 && got.size() < n; k++) @(posedge clk);
    if (got.size() < n) begin
      err_count++;
      conclude();
    end
  endtask
  initial begin
    seed = 32'hADA3A462;
    req = '0;
    act = 1'b0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rd(`OFS_CTRL, 32'h1);
    rd(`OFS_CLASS, 32'h6);
    rd(`OFS_SVC, 32'hA0);
    rd(`OFS_CAP, 32'hC0);
    rd(`OFS_MASK, 32'h0);
    rd(`OFS_STATE, 32'h00008000);
    rd(8'h1C, 32'h0);
    // silent while disabled, then an answer cut short by reset
    wr(`OFS_CTRL, 32'h0);
    act <= 1'b1;
    repeat (3000) @(posedge clk);
    chk(got.size(), 0);
    act <= 1'b0;
    wr(`OFS_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    act <= 1'b1; // reactivation at the same class
    wait_rx(2);
    act <= 1'b0;
    repeat (40) @(posedge clk);
    #1 chk(io_oe, 0);
    rd(`OFS_STATUS, 32'h4);
    // full answers over class masks 0 to 6 and one random mask, random service and capability data
    for (it = 0; it < 8; it++) begin
      m = (it == 7) ? 3'($random(seed)) : 3'(24'h02E711 >> (3 * it));
      cs = 2'($random(seed));
      sv = 8'($random(seed));
      cp = 24'($random(seed));
      wr(`OFS_CTRL, {24'h0, cs, 6'h01});
      wr(`OFS_CLASS, {29'h0, m});
      wr(`OFS_SVC, {24'h0, sv});
      wr(`OFS_CAP, {8'h0, cp});
      wr(`OFS_MASK, {29'h0, {3{it[0]}}});
      e = '{`ATR_TS, `ATR_T0, `ATR_TD1, `ATR_TD2, {cs, 3'h0, ((m == 3'h5) ? 3'h1 : m)},
            8'h80, 8'h31, sv, 8'h73, cp[23:16], cp[15:8], cp[7:0], 8'h00};
      for (i = 1; i < 12; i++) e[12] ^= e[i];
      got.delete(); // fresh answer, received character queue starts empty
      act <= 1'b1;
      wait_rx(13);
      for (i = 0; i < 13; i++) chk(got[i], e[i]);
      chk(got[3][3:0], 4'hF);
      chk(got[4][4:3], 2'h0);
      chk(got[4][2:0] == 3'h5, 0);
      chk(got[5], 8'h80);
      chk(got[6], 8'h31);
      chk(got[8], 8'h73);
      if (it < 7) chk(term_class(got[4][2:0]), 3'(24'h04C511 >> (3 * it)));
      repeat (150) @(posedge clk);
      #1 chk(irq, it[0]);
      rd(`OFS_STATE, {16'h0, 2'b11, 1'b0, ((m == 3'h5) ? 3'h1 : m), 4'hC, 4'hB, 2'b10});
      act <= 1'b0;
      repeat (40) @(posedge clk);
      rd(`OFS_STATUS, {29'h0, 1'b1, m == 3'h5, 1'b1});
      repeat (2) @(posedge clk);
      #1 chk(irq, 0);
    end
    conclude();
  end
endmodule // tb_card_atr_core
`default_nettype wire
